// file: system_control_registers.v
// What this block does
// - Stack index register reads and writes whole
// - Type zero clock select code table
// - Type one clock select code table
// - Bit three picks clock table, resets zero
// - Bit four enables fast oscillator
// - Bit two slow oscillator; off stops watchdog
// - Bit one enables watchdog, resets one
// - Bit zero picks reset pin role
// - Mask bits gate each interrupt source
// - Pending flags set by hardware, software clears
// - Pending layout matches mask, bit five reserved
// - Wide counter clock source selection codes
// - Selected counter bit change raises event
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "system_control_map.vh"

module system_control_registers (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire stack_push,
  input wire stack_pop,
  input wire third_timer_evt,
  input wire second_timer_evt,
  input wire comparator_evt,
  input wire converter_evt,
  input wire pin_group1_evt,
  input wire pin_group0_evt,
  input wire port_a_bit_four,
  input wire port_a_bit_zero,
  input wire fast_osc_clk,
  input wire crystal_osc_clk,
  input wire slow_osc_clk,
  output reg [7:0] call_stack_index,
  output reg [1:0] sysclk_source,
  output reg [2:0] sysclk_div_log2,
  output reg sysclk_code_reserved,
  output reg fast_internal_oscillator_en,
  output reg slow_internal_oscillator_en,
  output reg watchdog_en,
  output reg external_reset_input_sel,
  output reg irq
);

  // ----------------------------------------
  // Clock select decode
  // ----------------------------------------
  // Returns {reserved, source[1:0], divide log2[2:0]}
  function [5:0] clk_decode;
    input type1;
    input [2:0] code;
    begin
      if (!type1) begin
        case (code)
          3'h0: clk_decode = {1'b0, `CLKSRC_FAST, 3'h2};
          3'h1: clk_decode = {1'b0, `CLKSRC_FAST, 3'h1};
          3'h3: clk_decode = {1'b0, `CLKSRC_CRYSTAL, 3'h2};
          3'h4: clk_decode = {1'b0, `CLKSRC_CRYSTAL, 3'h1};
          3'h5: clk_decode = {1'b0, `CLKSRC_CRYSTAL, 3'h0};
          3'h6: clk_decode = {1'b0, `CLKSRC_SLOW, 3'h2};
          3'h7: clk_decode = {1'b0, `CLKSRC_SLOW, 3'h0};
          default: clk_decode = {1'b1, `CLKSRC_NONE, 3'h0};
        endcase
      end else begin
        case (code)
          3'h0: clk_decode = {1'b0, `CLKSRC_FAST, 3'h4};
          3'h1: clk_decode = {1'b0, `CLKSRC_FAST, 3'h3};
          3'h2: clk_decode = {1'b0, `CLKSRC_SLOW, 3'h4};
          3'h3: clk_decode = {1'b0, `CLKSRC_FAST, 3'h5};
          3'h4: clk_decode = {1'b0, `CLKSRC_FAST, 3'h6};
          3'h5: clk_decode = {1'b0, `CLKSRC_CRYSTAL, 3'h3};
          default: clk_decode = {1'b1, `CLKSRC_NONE, 3'h0};
        endcase
      end
    end
  endfunction

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  reg [7:0] stack_q;
  reg [7:0] stack_d;
  reg [7:0] clkmode_q;
  reg [7:0] mask_q;
  reg [7:0] pending_q;
  reg [7:0] pending_d;
  reg [7:0] tmode_q;
  reg [15:0] wcount_q;
  reg [15:0] wcount_d;
  reg [5:0] presc_q;
  reg [5:0] presc_d;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Stage one feeds only stage two; edges come from stages two and three
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  reg [4:0] sync3_q;
  wire [4:0] raw_in;
  wire a4_fall;
  wire a0_fall;
  wire fast_tick;
  wire crystal_tick;
  wire slow_tick;

  assign raw_in = {slow_osc_clk, crystal_osc_clk, fast_osc_clk,
                   port_a_bit_zero, port_a_bit_four};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      sync3_q <= 5'h00;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Oscillators slower than half of pclk only; faster ones alias
  assign a4_fall = sync3_q[0] & ~sync2_q[0];
  assign a0_fall = sync3_q[1] & ~sync2_q[1];
  assign fast_tick = sync2_q[2] & ~sync3_q[2];
  assign crystal_tick = sync2_q[3] & ~sync3_q[3];
  assign slow_tick = sync2_q[4] & ~sync3_q[4];

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire [9:0] idx;
  wire aligned;
  wire setup;
  wire wr_en;
  reg mapped;
  reg [7:0] rd_byte;

  assign idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;

  always @* begin
    mapped = aligned;
    rd_byte = 8'h00;
    case (idx)
      `IDX_CALL_STACK_INDEX: rd_byte = stack_q;
      `IDX_CLOCK_MODE_CONTROL: rd_byte = clkmode_q;
      `IDX_INTERRUPT_MASK: rd_byte = mask_q;
      `IDX_INTERRUPT_PENDING: rd_byte = pending_q;
      `IDX_WIDE_TIMER_MODE: rd_byte = tmode_q;
      `IDX_PENDING_CLEAR: rd_byte = 8'h00;
      `IDX_WIDE_COUNT_LOW: rd_byte = wcount_q[7:0];
      `IDX_WIDE_COUNT_HIGH: rd_byte = wcount_q[15:8];
      default: mapped = 1'b0;
    endcase
  end

  // Read data captured in setup; access phase always completes at once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      prdata <= (mapped && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // Stack index and configuration registers
  // ----------------------------------------
  always @* begin
    stack_d = stack_q;
    // relies on software keeping bit zero clear
    if (stack_push && !stack_pop)
      stack_d = stack_q + `STACK_STEP;
    else if (stack_pop && !stack_push)
      stack_d = stack_q - `STACK_STEP;
    if (wr_en && idx == `IDX_CALL_STACK_INDEX)
      stack_d = pwdata[7:0];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_q <= `RST_CALL_STACK_INDEX;
      clkmode_q <= `RST_CLOCK_MODE_CONTROL;
      mask_q <= `RST_INTERRUPT_MASK;
      tmode_q <= `RST_WIDE_TIMER_MODE;
    end else begin
      stack_q <= stack_d;
      if (wr_en && idx == `IDX_CLOCK_MODE_CONTROL)
        clkmode_q <= pwdata[7:0];
      // mask write, reserved bit held zero
      if (wr_en && idx == `IDX_INTERRUPT_MASK)
        mask_q <= pwdata[7:0] & `IRQ_IMPL_MASK;
      if (wr_en && idx == `IDX_WIDE_TIMER_MODE)
        tmode_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // Wide counter
  // ----------------------------------------
  reg src_tick;
  reg pre_hit;
  reg wide_evt;
  wire [2:0] src_code;
  wire [1:0] pre_code;
  wire [2:0] bit_sel;

  assign src_code = tmode_q[`WTM_SRC_HI:`WTM_SRC_LO];
  assign pre_code = tmode_q[`WTM_PRE_HI:`WTM_PRE_LO];
  assign bit_sel = tmode_q[`WTM_BIT_HI:`WTM_BIT_LO];

  always @* begin
    case (src_code)
      `WSRC_SYSCLK: src_tick = 1'b1;
      `WSRC_A4_FALL: src_tick = a4_fall;
      `WSRC_FAST: src_tick = fast_tick;
      `WSRC_CRYSTAL: src_tick = crystal_tick;
      `WSRC_SLOW: src_tick = slow_tick;
      `WSRC_A0_FALL: src_tick = a0_fall;
      default: src_tick = 1'b0;
    endcase
    case (pre_code)
      2'h0: pre_hit = 1'b1;
      2'h1: pre_hit = (presc_q[1:0] == 2'h3);
      2'h2: pre_hit = (presc_q[3:0] == 4'hf);
      default: pre_hit = (presc_q == 6'h3f);
    endcase
    presc_d = presc_q;
    wcount_d = wcount_q;
    wide_evt = 1'b0;
    if (src_tick) begin
      presc_d = presc_q + 6'h01;
      if (pre_hit) begin
        wcount_d = wcount_q + 16'h0001;
        wide_evt = wcount_d[{1'b1, bit_sel}] != wcount_q[{1'b1, bit_sel}];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 6'h00;
      wcount_q <= 16'h0000;
    end else begin
      presc_q <= presc_d;
      wcount_q <= wcount_d;
    end
  end

  // ----------------------------------------
  // Interrupt pending and request
  // ----------------------------------------
  wire [7:0] events;
  reg [7:0] clr_bits;

  assign events = {third_timer_evt, second_timer_evt, 1'b0, comparator_evt,
                   converter_evt, wide_evt, pin_group1_evt, pin_group0_evt};

  always @* begin
    clr_bits = 8'h00;
    // Writing zero to a pending bit clears it
    if (wr_en && idx == `IDX_INTERRUPT_PENDING)
      clr_bits = ~pwdata[7:0];
    // Separate write-one-to-clear register
    if (wr_en && idx == `IDX_PENDING_CLEAR)
      clr_bits = pwdata[7:0];
    // set beats clear in the same cycle
    pending_d = ((pending_q & ~clr_bits) | events) & `IRQ_IMPL_MASK;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pending_q <= `RST_INTERRUPT_PENDING;
    else
      pending_q <= pending_d;
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  wire [5:0] clk_sel;

  assign clk_sel = clk_decode(clkmode_q[`CMC_TYPE], clkmode_q[`CMC_SEL_HI:`CMC_SEL_LO]);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      call_stack_index <= `RST_CALL_STACK_INDEX;
      sysclk_source <= `CLKSRC_SLOW;
      sysclk_div_log2 <= 3'h0;
      sysclk_code_reserved <= 1'b0;
      fast_internal_oscillator_en <= 1'b1;
      slow_internal_oscillator_en <= 1'b1;
      watchdog_en <= 1'b1;
      external_reset_input_sel <= 1'b0;
      irq <= 1'b0;
    end else begin
      call_stack_index <= stack_q;
      sysclk_code_reserved <= clk_sel[5];
      sysclk_source <= clk_sel[4:3];
      sysclk_div_log2 <= clk_sel[2:0];
      fast_internal_oscillator_en <= clkmode_q[`CMC_FAST_EN];
      slow_internal_oscillator_en <= clkmode_q[`CMC_SLOW_EN];
      watchdog_en <= clkmode_q[`CMC_WDOG_EN] & clkmode_q[`CMC_SLOW_EN];
      external_reset_input_sel <= clkmode_q[`CMC_RST_PIN];
      irq <= |(pending_q & mask_q);
    end
  end

endmodule // system_control_registers

// file: system_control_map.vh
`ifndef SYSTEM_CONTROL_MAP_VH
`define SYSTEM_CONTROL_MAP_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_CALL_STACK_INDEX 10'h002
`define IDX_CLOCK_MODE_CONTROL 10'h003
`define IDX_INTERRUPT_MASK 10'h004
`define IDX_INTERRUPT_PENDING 10'h005
`define IDX_WIDE_TIMER_MODE 10'h006
`define IDX_PENDING_CLEAR 10'h007
`define IDX_WIDE_COUNT_LOW 10'h008
`define IDX_WIDE_COUNT_HIGH 10'h009

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CALL_STACK_INDEX 8'h00
`define RST_CLOCK_MODE_CONTROL 8'hf6
`define RST_INTERRUPT_MASK 8'h00
`define RST_INTERRUPT_PENDING 8'h00
`define RST_WIDE_TIMER_MODE 8'h00

// ----------------------------------------
// Clock mode fields
// ----------------------------------------
`define CMC_SEL_HI 7
`define CMC_SEL_LO 5
`define CMC_FAST_EN 4
`define CMC_TYPE 3
`define CMC_SLOW_EN 2
`define CMC_WDOG_EN 1
`define CMC_RST_PIN 0

// ----------------------------------------
// Interrupt bit positions and implemented mask
// ----------------------------------------
`define IRQ_THIRD_TIMER 7
`define IRQ_SECOND_TIMER 6
`define IRQ_COMPARATOR 4
`define IRQ_CONVERTER 3
`define IRQ_WIDE_COUNTER 2
`define IRQ_PIN_GROUP1 1
`define IRQ_PIN_GROUP0 0
`define IRQ_IMPL_MASK 8'hdf

// ----------------------------------------
// Wide timer mode fields and source codes
// ----------------------------------------
`define WTM_SRC_HI 7
`define WTM_SRC_LO 5
`define WTM_PRE_HI 4
`define WTM_PRE_LO 3
`define WTM_BIT_HI 2
`define WTM_BIT_LO 0
`define WSRC_STOP 3'h0
`define WSRC_SYSCLK 3'h1
`define WSRC_A4_FALL 3'h3
`define WSRC_FAST 3'h4
`define WSRC_CRYSTAL 3'h5
`define WSRC_SLOW 3'h6
`define WSRC_A0_FALL 3'h7

// ----------------------------------------
// System clock source encoding on outputs
// ----------------------------------------
`define CLKSRC_NONE 2'h0
`define CLKSRC_FAST 2'h1
`define CLKSRC_CRYSTAL 2'h2
`define CLKSRC_SLOW 2'h3

// Stack grows by one 16-bit return location
`define STACK_STEP 8'h02

`endif

// file: system_control_registers_properties.sv
`timescale 1ns/1ps
module sysctl_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire stack_push,
  input wire stack_pop,
  input wire [7:0] call_stack_index,
  input wire fast_internal_oscillator_en,
  input wire slow_internal_oscillator_en,
  input wire watchdog_en,
  input wire external_reset_input_sel,
  input wire irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  reg [7:0] w1_q;
  reg [7:0] w2_q;
  wire setup = psel && !penable;
  wire wr = psel && penable && pready && pwrite;
  wire bad = paddr[1:0] != 2'h0 || paddr[11:2] < 10'h002 || paddr[11:2] > 10'h009;
  always @(posedge pclk) begin
    w1_q <= pwdata[7:0];
    w2_q <= w1_q;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ready_one_shot:
    assert property (setup |=> pready ##1 !pready) else $error("pready not one access cycle");
  a_unmapped_error:
    assert property (setup && bad |=> pslverr && prdata == 32'h0) else $error("no slave error");
  a_read_upper_zero:
    assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_stack_write_copy:
    assert property (wr && paddr == 12'h008 |-> ##2 call_stack_index == w2_q)
    else $error("stack index not loaded");
  a_stack_push_step:
    assert property (stack_push && !stack_pop && !(wr && paddr == 12'h008)
      |-> ##2 call_stack_index == $past(call_stack_index) + 8'h02) else $error("push step wrong");
  a_clock_enables_follow:
    assert property (wr && paddr == 12'h00c |-> ##2 {fast_internal_oscillator_en,
      slow_internal_oscillator_en, watchdog_en, external_reset_input_sel}
      == {w2_q[4], w2_q[2], w2_q[2] & w2_q[1], w2_q[0]}) else $error("enables wrong");
  a_watchdog_needs_slow:
    assert property (!slow_internal_oscillator_en |-> !watchdog_en) else $error("watchdog on");
  a_irq_mask_clear:
    assert property (wr && paddr == 12'h010 && pwdata[7:0] == 8'h00 |-> ##2 !irq)
    else $error("irq with mask clear");
  c_clock_write: cover property (wr && paddr == 12'h00c);
  c_irq_rise: cover property ($rose(irq));
  c_slave_error: cover property (pslverr);
endmodule // sysctl_checker

bind system_control_registers sysctl_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .stack_push, .stack_pop, .call_stack_index,
  .fast_internal_oscillator_en, .slow_internal_oscillator_en, .watchdog_en,
  .external_reset_input_sel, .irq);

// file: tb.sv
`timescale 1ns/1ps
module tb;
  // Clock select expectations {reserved, source, div_log2}, index {type, code}
  localparam [127:0] CLK_TBL = 128'h2020130e0d1c0b0c181a10111220090a;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stack_push = 1'b0, stack_pop = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [7:0] evt = 8'h00;
  reg [4:0] osc = 5'h00;
  reg [31:0] rd;
  reg [7:0] d, m;
  wire [31:0] prdata;
  wire pready, pslverr, irq, sysclk_code_reserved, fast_en, slow_en, wd_en, ext_sel;
  wire [7:0] csi;
  wire [1:0] src;
  wire [2:0] dvl;
  integer seed = 10954, errors = 0, total_checks = 0, cyc = 0, i, k, t0;
  system_control_registers i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stack_push(stack_push), .stack_pop(stack_pop),
    .third_timer_evt(evt[7]), .second_timer_evt(evt[6]), .comparator_evt(evt[4]),
    .converter_evt(evt[3]), .pin_group1_evt(evt[1]), .pin_group0_evt(evt[0]),
    .port_a_bit_four(~osc[2]), .port_a_bit_zero(osc[2]), .fast_osc_clk(osc[2]),
    .crystal_osc_clk(~osc[2]), .slow_osc_clk(~osc[2]), .call_stack_index(csi),
    .sysclk_source(src), .sysclk_div_log2(dvl), .sysclk_code_reserved(sysclk_code_reserved),
    .fast_internal_oscillator_en(fast_en), .slow_internal_oscillator_en(slow_en),
    .watchdog_en(wd_en), .external_reset_input_sel(ext_sel), .irq(irq));
  always #2 pclk = ~pclk;
  // Slow oscillators: high and low four cycles each
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    osc <= osc + 5'h01;
    if (cyc == 100000) begin
      errors = errors + 1;
      tally_and_finish;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input [63:0] got, input [63:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input w, input [11:0] a, input [7:0] wd, input err);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      chk(pslverr, err);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task gap(input [7:0] md, input integer p);
    integer iv;
    begin
      iv = (256 << (md[2:0] + 2 * md[4:3])) * p;
      apb(1, 12'h018, md, 0);
      apb(1, 12'h01c, 8'h04, 0);
      tick(2);
      while (irq !== 1'b1) @(posedge pclk);
      t0 = cyc;
      apb(1, 12'h01c, 8'h04, 0);
      tick(2);
      while (irq !== 1'b1) @(posedge pclk);
      chk(cyc - t0 + p - 1 >= iv && cyc - t0 <= iv + p - 1, 1'b1);
    end
  endtask
  task tally_and_finish;
    begin
      if (errors == 0 && total_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    chk({sysclk_code_reserved, src, dvl, fast_en, slow_en, wd_en, ext_sel, irq}, 11'h31c);
    presetn <= 1'b1;
    for (i = 2; i < 7; i = i + 1) begin
      apb(0, {i[9:0], 2'b00}, 0, 0);
      chk(rd, i == 3 ? 32'hf6 : 32'h0);
    end
    for (i = 0; i < 16; i = i + 1) begin
      k = $random(seed);
      d = {i[2:0], k[4], i[3], k[2:0]};
      apb(1, 12'h00c, d, 0);
      tick(2);
      chk({sysclk_code_reserved, src, dvl}, CLK_TBL[i * 8 +: 6]);
      chk({fast_en, slow_en, wd_en, ext_sel}, {k[4], k[2], k[2] & k[1], k[0]});
      apb(0, 12'h00c, 0, 0);
      chk(rd, d);
    end
    k = $random(seed);
    apb(1, 12'h008, {k[7:1], 1'b0}, 0);
    d = {k[7:1], 1'b0} + 8'h02;
    @(posedge pclk);
    stack_push <= 1'b1;
    @(posedge pclk);
    stack_push <= 1'b0;
    apb(0, 12'h008, 0, 0);
    chk(rd, d);
    stack_pop <= 1'b1;
    @(posedge pclk);
    stack_pop <= 1'b0;
    tick(2);
    chk(csi, d - 8'h02);
    apb(1, 12'h010, 8'hff, 0);
    apb(0, 12'h010, 0, 0);
    chk(rd, 32'hdf);
    for (i = 0; i < 8; i = i + 1) begin
      m = 8'h01 << i;
      if (i != 2 && i != 5) begin
        apb(1, 12'h010, 8'h00, 0);
        evt <= m;
        @(posedge pclk);
        evt <= 8'h00;
        apb(0, 12'h014, 0, 0);
        chk({irq, rd}, {1'b0, 24'h0, m});
        apb(1, 12'h010, m, 0);
        tick(2);
        chk(irq, 1'b1);
        if (i[0])
          apb(1, 12'h01c, m, 0);
        else
          apb(1, 12'h014, ~m, 0);
        apb(0, 12'h014, 0, 0);
        chk({irq, rd}, 33'h0);
      end
    end
    apb(0, 12'h040, 0, 1);
    chk(rd, 32'h0);
    apb(1, 12'h019, 8'hff, 1);
    apb(1, 12'h020, 8'hff, 0);
    apb(0, 12'h018, 0, 0);
    chk(rd, 32'h0);
    apb(0, 12'h024, 0, 0);
    chk(rd, 32'h0);
    apb(0, 12'h020, 0, 0);
    k = rd;
    tick(50);
    apb(0, 12'h020, 0, 0);
    chk(rd, k);
    apb(1, 12'h010, 8'h04, 0);
    for (i = 0; i < 4; i = i + 1)
      gap({3'h1, i[1:0], 2'b00, ~i[0]}, 1);
    for (i = 3; i < 8; i = i + 1)
      gap({i[2:0], 5'h00}, 8);
    tally_and_finish;
  end
endmodule // tb
